// *** logic/aaalu_pkg.sv ***
package aaalu_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned NIB_W = 4;
  // Sign bit index of a byte
  localparam int unsigned MSB = 7;
  // Execution length in instruction cycles
  localparam logic [1:0] CYC_NORMAL = 2'h1;
  localparam logic [1:0] CYC_PCL = 2'h2;

  typedef enum logic [2:0] {
    AAALU_OP_ADC_ACC = 3'b000,
    AAALU_OP_ADD_WITH_BIT_IN_TO_MEMORY = 3'b001,
    AAALU_OP_ADD_ACC = 3'b010,
    AAALU_OP_ADD_IMM = 3'b011,
    AAALU_OP_SUM_INTO_MEMORY = 3'b100,
    AAALU_OP_AND_ACC = 3'b101
  } aaalu_op_t;

  typedef struct packed {
    logic signed_wrap_flag;
    logic zero_flag;
    logic nibble_out_flag;
    logic carry_flag;
  } aaalu_flags_t;

  typedef struct packed {
    aaalu_op_t op;
    logic [DATA_W-1:0] mem_data;
    logic [DATA_W-1:0] imm_data;
    logic dest_is_pcl;
  } aaalu_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] result;
    logic to_acc;
    logic to_mem;
    logic to_pcl;
    aaalu_flags_t flags;
    logic [3:0] flag_we;
  } aaalu_res_t;

endpackage : aaalu_pkg

// *** logic/aaalu_adder.sv ***
`timescale 1ns/100ps
`default_nettype none
module aaalu_adder
(
  input wire logic [aaalu_pkg::DATA_W-1:0] i_a,
  input wire logic [aaalu_pkg::DATA_W-1:0] i_b,
  input wire logic i_cin,
  output logic [aaalu_pkg::DATA_W-1:0] o_sum,
  output aaalu_pkg::aaalu_flags_t o_flags
);
  logic [aaalu_pkg::NIB_W:0] lo;
  logic [aaalu_pkg::NIB_W:0] hi;

  always_comb
  begin
    lo = {1'b0, i_a[aaalu_pkg::NIB_W-1:0]} + {1'b0, i_b[aaalu_pkg::NIB_W-1:0]}
      + {{aaalu_pkg::NIB_W{1'b0}}, i_cin};
    hi = {1'b0, i_a[aaalu_pkg::DATA_W-1:aaalu_pkg::NIB_W]}
      + {1'b0, i_b[aaalu_pkg::DATA_W-1:aaalu_pkg::NIB_W]}
      + {{aaalu_pkg::NIB_W{1'b0}}, lo[aaalu_pkg::NIB_W]};
    o_sum = {hi[aaalu_pkg::NIB_W-1:0], lo[aaalu_pkg::NIB_W-1:0]};
    o_flags.carry_flag = hi[aaalu_pkg::NIB_W];
    o_flags.nibble_out_flag = lo[aaalu_pkg::NIB_W];
    // Same-sign operands giving a different-sign result
    o_flags.signed_wrap_flag = (i_a[aaalu_pkg::MSB] == i_b[aaalu_pkg::MSB])
      && (o_sum[aaalu_pkg::MSB] != i_a[aaalu_pkg::MSB]);
    o_flags.zero_flag = (o_sum == '0);
  end
endmodule : aaalu_adder
`default_nettype wire

// *** logic/aaalu_core.sv ***
// What this block does
// - Add-with-carry to the work register sums it, the memory byte and carry, result to the work register, four flags updated.
// - Add-with-carry to memory sums the work register, memory byte and carry, result to memory, four flags updated.
// - Plain add of a memory byte to the work register without carry-in, result to the work register, four flags updated.
// - Plain add of the immediate byte to the work register without carry-in, four flags updated.
// - Plain add of the work register to a memory byte without carry-in, result to memory, four flags updated.
// - AND of the work register with a memory byte, result to the work register, only zero updated.
// - Any of these writing the program counter low byte takes two instruction cycles instead of one.
`timescale 1ns/100ps
`default_nettype none
module aaalu_core
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire aaalu_pkg::aaalu_req_t i_req,
  output logic o_busy,
  output logic o_done,
  output logic [aaalu_pkg::DATA_W-1:0] o_acc,
  output aaalu_pkg::aaalu_flags_t o_flags,
  output aaalu_pkg::aaalu_res_t o_res
);
  typedef enum logic [1:0] {
    AAALU_ST_IDLE = 2'b00,
    AAALU_ST_WAIT = 2'b01
  } aaalu_state_t;

  aaalu_state_t state_q, state_d;
  logic [aaalu_pkg::DATA_W-1:0] acc_q, acc_d;
  aaalu_pkg::aaalu_flags_t flags_q, flags_d;
  aaalu_pkg::aaalu_res_t res_q, res_d, res_hold_q, res_hold_d;
  logic done_q, done_d;
  logic busy_q, busy_d;
  logic [aaalu_pkg::DATA_W-1:0] add_b;
  logic add_cin;
  logic [aaalu_pkg::DATA_W-1:0] sum;
  aaalu_pkg::aaalu_flags_t add_flags;
  aaalu_pkg::aaalu_res_t res_now;

  // Operand selection: immediate or memory, carry-in only for add-with-carry
  always_comb
  begin
    add_b = (i_req.op == aaalu_pkg::AAALU_OP_ADD_IMM) ? i_req.imm_data : i_req.mem_data;
    add_cin = 1'b0;
    if (i_req.op == aaalu_pkg::AAALU_OP_ADC_ACC
        || i_req.op == aaalu_pkg::AAALU_OP_ADD_WITH_BIT_IN_TO_MEMORY)
    begin
      add_cin = flags_q.carry_flag;
    end
  end

  aaalu_adder u_adder
  (
    .i_a(acc_q),
    .i_b(add_b),
    .i_cin(add_cin),
    .o_sum(sum),
    .o_flags(add_flags)
  );

  always_comb
  begin
    res_now = '0;
    res_now.result = sum;
    res_now.flags = add_flags;
    res_now.flag_we = 4'hf;
    res_now.to_pcl = i_req.dest_is_pcl;
    unique case (i_req.op)
      aaalu_pkg::AAALU_OP_ADC_ACC: res_now.to_acc = 1'b1;
      aaalu_pkg::AAALU_OP_ADD_WITH_BIT_IN_TO_MEMORY: res_now.to_mem = 1'b1;
      aaalu_pkg::AAALU_OP_ADD_ACC: res_now.to_acc = 1'b1;
      aaalu_pkg::AAALU_OP_ADD_IMM: res_now.to_acc = 1'b1;
      aaalu_pkg::AAALU_OP_SUM_INTO_MEMORY: res_now.to_mem = 1'b1;
      aaalu_pkg::AAALU_OP_AND_ACC:
      begin
        res_now.result = acc_q & i_req.mem_data;
        res_now.to_acc = 1'b1;
        res_now.flags = flags_q;
        res_now.flags.zero_flag = (res_now.result == '0);
        res_now.flag_we = 4'h4;
      end
      default:
      begin
        // Illegal codes do nothing
        res_now.flag_we = 4'h0;
        res_now.to_pcl = 1'b0;
      end
    endcase
    // A program counter low destination cancels the accumulator and memory writes
    if (res_now.to_pcl)
    begin
      res_now.to_acc = 1'b0;
      res_now.to_mem = 1'b0;
    end
  end

  always_comb
  begin
    state_d = state_q;
    acc_d = acc_q;
    flags_d = flags_q;
    res_d = res_q;
    res_hold_d = res_hold_q;
    done_d = 1'b0;
    busy_d = busy_q;
    res_d.to_acc = 1'b0;
    res_d.to_mem = 1'b0;
    res_d.to_pcl = 1'b0;
    unique case (state_q)
      AAALU_ST_IDLE:
      begin
        if (i_start)
        begin
          if (res_now.to_pcl)
          begin
            // Program counter change costs a second cycle for the refetch
            res_hold_d = res_now;
            state_d = AAALU_ST_WAIT;
            busy_d = 1'b1;
          end
          else
          begin
            res_d = res_now;
            done_d = 1'b1;
            if (res_now.to_acc)
            begin
              acc_d = res_now.result;
            end
            // Illegal codes carry adder flags but no write enable, so they must not land
            if (res_now.flag_we != '0)
            begin
              flags_d = res_now.flags;
            end
          end
        end
      end
      AAALU_ST_WAIT:
      begin
        res_d = res_hold_q;
        if (res_hold_q.flag_we != '0)
        begin
          flags_d = res_hold_q.flags;
        end
        done_d = 1'b1;
        busy_d = 1'b0;
        state_d = AAALU_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_q <= AAALU_ST_IDLE;
      acc_q <= '0;
      flags_q <= '0;
      res_q <= '0;
      res_hold_q <= '0;
      done_q <= 1'b0;
      busy_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      acc_q <= acc_d;
      flags_q <= flags_d;
      res_q <= res_d;
      res_hold_q <= res_hold_d;
      done_q <= done_d;
      busy_q <= busy_d;
    end
  end

  assign o_acc = acc_q;
  assign o_flags = flags_q;
  assign o_res = res_q;
  assign o_done = done_q;
  assign o_busy = busy_q;

endmodule : aaalu_core
`default_nettype wire

// *** verif/aaalu_core_props.sv ***
`timescale 1ns/100ps
`default_nettype none
module aaalu_core_props (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire aaalu_pkg::aaalu_req_t i_req,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic [7:0] o_acc,
  input wire aaalu_pkg::aaalu_flags_t o_flags,
  input wire aaalu_pkg::aaalu_res_t o_res
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  wire g = i_start && !o_busy && !i_req.dest_is_pcl;
  wire [2:0] k = i_req.op;
  wire [7:0] m = i_req.mem_data;
  wire c = o_flags.carry_flag;
  // Expected results formed here so that $past only ever sees a plain signal
  wire [7:0] s_c = o_acc + m + {7'h0, c};
  wire [7:0] s_n = o_acc + m;
  wire [7:0] s_i = o_acc + i_req.imm_data;
  wire [7:0] s_a = o_acc & m;
  property p_two; i_start && !o_busy && i_req.dest_is_pcl |=> o_busy ##1 o_done && o_res.to_pcl;
  endproperty
  a_two: assert property (p_two) else $error("pcl");
  property p_adc; g && k == 3'h0 |=> o_done && o_acc == $past(s_c); endproperty
  a_adc: assert property (p_adc) else $error("adc");
  property p_add_with_bit_in_to_memory; g && k == 3'h1 |=> o_res.to_mem && o_res.result == $past(s_c);
  endproperty
  a_add_with_bit_in_to_memory: assert property (p_add_with_bit_in_to_memory) else $error("add_with_bit_in_to_memory");
  property p_add; g && k == 3'h2 |=> o_acc == $past(s_n); endproperty
  a_add: assert property (p_add) else $error("add");
  property p_imm; g && k == 3'h3 |=> o_acc == $past(s_i); endproperty
  a_imm: assert property (p_imm) else $error("imm");
  property p_sum_into_memory; g && k == 3'h4 |=> o_res.to_mem && o_res.result == $past(s_n); endproperty
  a_sum_into_memory: assert property (p_sum_into_memory) else $error("sum_into_memory");
  property p_and; g && k == 3'h5 |=> o_acc == $past(s_a) && $stable(c); endproperty
  a_and: assert property (p_and) else $error("and");
  property p_zero; o_done |-> o_res.flags.zero_flag == (o_res.result == 8'h0); endproperty
  a_zero: assert property (p_zero) else $error("zero");
endmodule : aaalu_core_props
`default_nettype wire

// *** verif/aaalu_mem.sv ***
`timescale 1ns/100ps
`default_nettype none
module aaalu_mem (
  input wire logic i_sys_clk,
  input wire logic [3:0] i_addr,
  input wire aaalu_pkg::aaalu_res_t i_res,
  output logic [7:0] o_rd
);
  logic [7:0] mem [16];
  initial for (int i = 0; i < 16; i++) mem[i] = 8'(i * 37);
  assign o_rd = mem[i_addr];
  // Write lands at the edge closing the done cycle, so the address must hold until then
  always @(posedge i_sys_clk) if (i_res.to_mem) mem[i_addr] <= i_res.result;
endmodule : aaalu_mem
`default_nettype wire

// *** verif/tb_aaalu_core.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_aaalu_core;
  logic i_sys_clk = 0, i_rst = 1, i_start = 0, o_busy, o_done;
  logic [7:0] o_acc, rd;
  logic [3:0] adr = 4'h0;
  aaalu_pkg::aaalu_req_t i_req = '0;
  aaalu_pkg::aaalu_flags_t o_flags;
  aaalu_pkg::aaalu_res_t o_res;
  int miscompares = 0, total_checks = 0, acc = 0, cy = 0, hc = 0, ov = 0, zf = 0;
  aaalu_core dut (.i_sys_clk, .i_rst, .i_start, .i_req, .o_busy, .o_done, .o_acc, .o_flags,
    .o_res);
  aaalu_mem mem (.i_sys_clk, .i_addr(adr), .i_res(o_res), .o_rd(rd));
  initial forever #10 i_sys_clk = ~i_sys_clk;
  task automatic chk(input bit ok);
    total_checks++;
    if (!ok)
    begin
      miscompares++;
      $display("[FAIL] %0t bad", $time);
    end
  endtask : chk
  task automatic conclude;
    if (miscompares == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  // A PROGRAM_COUNTER_LOW target leaves the work register alone, so the model only updates acc otherwise
  task automatic op(input int o, a, b, p);
    int n, r, ci;
    @(negedge i_sys_clk);
    adr = 4'(a);
    #1;
    i_req = '{aaalu_pkg::aaalu_op_t'(o), rd, 8'(b), 1'(p)};
    i_start = 1;
    if (o != 3) b = rd;
    ci = o < 2 ? cy : 0;
    r = o == 5 ? acc & b : acc + b + ci;
    if (o < 5)
    begin
      hc = (acc % 16 + b % 16 + ci) > 15;
      ov = (acc / 128 == b / 128) && ((r / 128) % 2 != acc / 128);
    end
    zf = r % 256 == 0;
    n = 0;
    do
    begin
      @(negedge i_sys_clk);
      i_start = 0;
      n++;
    end while (o_done !== 1 && n < 4);
    chk(n == (p ? 2 : 1));
    if (o < 5) cy = r > 255;
    chk(o_flags.carry_flag === 1'(cy));
    chk(o_flags.nibble_out_flag === 1'(hc));
    chk(o_flags.signed_wrap_flag === 1'(ov));
    chk(o_flags.zero_flag === 1'(zf));
    chk(o_res.to_mem === 1'(!p && (o == 1 || o == 4)));
    chk(o_res.to_pcl === 1'(p));
    chk(o_res.result === 8'(r));
    if (!p && o != 1 && o != 4) acc = r % 256;
    chk(o_acc === 8'(acc));
    if (n == 4) conclude;
  endtask : op
  initial
  begin
    void'($urandom(32'ha2e5));
    repeat (10) @(negedge i_sys_clk);
    i_rst = 0;
    for (int i = 0; i < 12; i++) op(i % 6, i, 255, i / 6);
    repeat (200) op($urandom % 6, $urandom, $urandom % 256, $urandom % 5 == 0);
    conclude;
  end
endmodule : tb_aaalu_core
bind aaalu_core aaalu_core_props u_props (.i_sys_clk, .i_rst, .i_start, .i_req, .o_busy,
  .o_done, .o_acc, .o_flags, .o_res);
`default_nettype wire
